// >>> ccpd_chk.sv
`default_nettype none
// ---------------------------------------------------------------
// Port checker for the duty-cycle channel
// ---------------------------------------------------------------
module ccpd_chk (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rstn,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Channel
   input wire logic        sleep,
   input wire logic        pwm_out_q,
   input wire logic        adc_trigger_q,
   input wire logic        irq_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Steps of a transfer
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence b_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   AST_WR_ANSWER: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
   AST_WR_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   AST_B_STANDS: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   AST_RD_ANSWER: assert property (rd_take |-> ##[1:2] s_axi_rvalid)
      else $error("read not answered");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   AST_RD_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   // Sleep must not move the pin at all
   AST_SLEEP_FREEZE: assert property (sleep ##1 sleep |-> $stable(pwm_out_q))
      else $error("pin moved in sleep");
   AST_TRIG_PULSE: assert property (adc_trigger_q |=> !adc_trigger_q)
      else $error("trigger longer than a cycle");
   // Interrupt only drops after a clear or enable write
   AST_IRQ_FALL: assert property ($fell(irq_q) |->
      $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("irq dropped without a write");
endmodule
bind ccpd_top ccpd_chk u_chk (
   .ref_clk(ref_clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sleep(sleep),
   .pwm_out_q(pwm_out_q), .adc_trigger_q(adc_trigger_q), .irq_q(irq_q));
`default_nettype wire

// >>> ccpd_consts.vh
`ifndef CCPD_CONSTS_VH
`define CCPD_CONSTS_VH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define CCPD_ADDR_CTRL     8'h00
`define CCPD_ADDR_WLOW     8'h04
`define CCPD_ADDR_WHIGH    8'h08
`define CCPD_ADDR_PERIOD   8'h0c
`define CCPD_ADDR_TIMER    8'h10
`define CCPD_ADDR_PRESC    8'h14
`define CCPD_ADDR_STATUS   8'h18
`define CCPD_ADDR_CLEAR    8'h1c
`define CCPD_ADDR_ENABLE   8'h20
`define CCPD_ADDR_TRIGSEL  8'h24

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CCPD_CTRL_EN       7
`define CCPD_CTRL_OUT      5
`define CCPD_CTRL_FMT      4
`define CCPD_MODE_PWM      4'hf
`define CCPD_CTRL_WMASK    8'h9f

// ---------------------------------------------------------------
// Prescale select codes
// ---------------------------------------------------------------
`define CCPD_PS_1          2'h0
`define CCPD_PS_4          2'h1
`define CCPD_PS_16         2'h2
`define CCPD_PS_64         2'h3

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CCPD_RST_CTRL      8'h00
`define CCPD_RST_BYTE      8'h00
`define CCPD_RST_PERIOD    8'hff

// Status bits
`define CCPD_ST_EVENT      0
`define CCPD_ST_PERIOD     1

`define CCPD_AXI_OKAY      2'h0
`define CCPD_AXI_SLVERR    2'h2

`endif

// >>> ccpd_load.sv
`default_nettype none
// ---------------------------------------------------------------
// Load on the channel pin: measures each high pulse in clocks
// ---------------------------------------------------------------
module ccpd_load (
   // Clock and pin
   input  wire logic        ref_clk,
   input  wire logic        pwm_in,
   // Measurement
   output var  logic [15:0] hi_len,
   output var  logic        hi_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_q = 16'h0;
   // Count high samples; report once on the fall
   always @(posedge ref_clk) begin
      hi_done <= !pwm_in && (cnt_q != 16'h0);
      hi_len  <= cnt_q;
      cnt_q   <= pwm_in ? cnt_q + 16'h1 : 16'h0;
   end
endmodule
`default_nettype wire

// >>> ccpd_prescaler.v
`default_nettype none
// ---------------------------------------------------------------
// Period-timer prescaler: one tick every 1, 4, 16 or 64 steps of run
// ---------------------------------------------------------------
`include "ccpd_consts.vh"
module ccpd_prescaler (
   // Clock and reset
   input  wire       ref_clk,
   input  wire       rstn,
   // Control
   input  wire       run,
   input  wire [1:0] sel,
   // Results
   output reg  [5:0] cnt_q,
   output wire       tick,
   output wire [1:0] sub_bits
);
   reg [5:0] last;

   // Terminal count per prescale setting
   always @* begin
      case (sel)
         `CCPD_PS_1:  last = 6'h00;
         `CCPD_PS_4:  last = 6'h03;
         `CCPD_PS_16: last = 6'h0f;
         default:     last = 6'h3f;
      endcase
   end

   assign tick = run && (cnt_q == last);

   // Top two bits of the active count range form the sub-count
   assign sub_bits = (sel == `CCPD_PS_4)  ? cnt_q[1:0] :
                     (sel == `CCPD_PS_16) ? cnt_q[3:2] : cnt_q[5:4];

   // Count frozen while not running so a wake resumes in place
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 6'h00;
      end else if (run) begin
         cnt_q <= tick ? 6'h00 : cnt_q + 6'h01;
      end
   end
endmodule
`default_nettype wire

// >>> ccpd_top.v
`default_nettype none
// Function
// - Pulse width is a 10-bit value held in the high/low byte pair
// - Width placement within the byte pair follows the alignment bit
// - Byte writes accepted anytime; active buffer loads only at period match
// - High time equals width times clock period times prescale factor
// - Duty double-buffered via byte pair plus 10-bit buffer, glitch free
// - Time base is 8-bit timer with two low sub-count bits appended
// - Sub bits from clock phase at 1:1 prescale, else from prescaler
// - Output cleared when time base equals buffered width
// - Resolution is log2(4*(period+1)); ten bits only at period 255
// - Width beyond period never clears the pin; it is set each period and stays high
// - Sleep freezes timer and channel state; resume from held count
// - All timing derived from the system clock
// - Any reset returns all channel registers to reset values
// - Format 0 right-aligned; format 1 left-aligned byte layout
// - After timer equals period: clear timer, set output unless zero, load buffer
`include "ccpd_consts.vh"
module ccpd_top (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rstn,
   // AXI4-Lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Device state
   input  wire        sleep,
   // Channel outputs
   output reg         pwm_out_q,
   output reg         adc_trigger_q,
   output reg         irq_q
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg  [7:0] ctrl_q;
   reg  [7:0] wlow_q;
   reg  [7:0] whigh_q;
   reg  [7:0] period_q;
   reg  [7:0] timer_q;
   reg  [1:0] presc_q;
   reg  [1:0] status_q;
   reg  [1:0] irq_en_q;
   reg        trig_sel_q;
   reg  [9:0] duty_buf_q;
   reg  [1:0] phase_q;
   reg  [7:0] aw_addr_q;
   reg        aw_have_q;
   reg [31:0] w_data_q;
   reg  [3:0] w_strb_q;
   reg        w_have_q;

   wire       pwm_mode;
   wire       run;
   wire       ps_tick;
   wire [1:0] ps_sub;
   wire [5:0] ps_cnt;
   wire       tmr_tick;
   wire       period_hit;
   wire [9:0] width_sw;
   wire [9:0] time_base;
   wire       wr_go;
   wire       clear_hit;
   wire       width_hit;
   wire       ps_step;
   wire       step_end;
   wire [9:0] tb_next;
   reg  [5:0] step_mask;

   assign pwm_mode = ctrl_q[`CCPD_CTRL_EN] && (ctrl_q[3:0] == `CCPD_MODE_PWM);
   assign run      = !sleep && pwm_mode;

   // ------------------------------------------------------------
   // Time base
   // ------------------------------------------------------------
   ccpd_prescaler u_presc (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .run      (ps_step),
      .sel      (presc_q),
      .cnt_q    (ps_cnt),
      .tick     (ps_tick),
      .sub_bits (ps_sub)
   );

   // Clock phase counter; the prescaler advances once per four phases
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         phase_q <= 2'h0;
      end else if (run) begin
         phase_q <= phase_q + 2'h1;
      end
   end

   assign ps_step    = run && (phase_q == 2'h3);
   // Prescaler tick already implies the last phase
   assign tmr_tick   = ps_tick;
   assign period_hit = tmr_tick && (timer_q == period_q);
   // clock phase at 1:1, prescaler bits otherwise
   assign time_base  = {timer_q, (presc_q == `CCPD_PS_1) ? phase_q : ps_sub};

   // Width placement: right or left aligned
   assign width_sw = ctrl_q[`CCPD_CTRL_FMT] ? {whigh_q, wlow_q[7:6]}
                                            : {whigh_q[1:0], wlow_q};

   // Period timer; each 10-bit step lasts one clock times prescale
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         timer_q <= 8'h00;
      end else if (period_hit) begin
         timer_q <= 8'h00;
      end else if (tmr_tick) begin
         timer_q <= timer_q + 8'h01;
      end
   end

   // Active duty buffer reloaded only at the period rollover
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         duty_buf_q <= 10'h000;
      end else if (period_hit) begin
         duty_buf_q <= width_sw;
      end
   end

   // Prescaler bits below the sub-count; the time base steps as they wrap
   always @* begin
      case (presc_q)
         `CCPD_PS_4:  step_mask = 6'h00;
         `CCPD_PS_16: step_mask = 6'h03;
         default:     step_mask = 6'h0f;
      endcase
   end

   assign step_end = (presc_q == `CCPD_PS_1) ? run :
                     (ps_step && ((ps_cnt & step_mask) == step_mask));
   assign tb_next  = time_base + 10'h001;

   // Match on the value about to be taken, so the pin falls after exactly
   // width steps; a width above the period never matches
   assign width_hit = step_end && (tb_next == duty_buf_q) &&
                      !period_hit;

   // Output latch; disabled channel forces low, sleep freezes it
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pwm_out_q <= 1'b0;
      end else if (!pwm_mode) begin
         pwm_out_q <= 1'b0;
      end else if (sleep) begin
         pwm_out_q <= pwm_out_q;
      end else if (period_hit) begin
         pwm_out_q <= (width_sw != 10'h000);
      end else if (width_hit) begin
         pwm_out_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Events, interrupt and trigger
   // ------------------------------------------------------------
   assign wr_go     = aw_have_q && w_have_q && !s_axi_bvalid;
   assign clear_hit = wr_go && (aw_addr_q == `CCPD_ADDR_CLEAR) && w_strb_q[0];

   // Sticky status; a new event wins over a simultaneous clear
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         status_q <= 2'h0;
      end else begin
         status_q <= (status_q & ~(clear_hit ? w_data_q[1:0] : 2'h0)) |
                     {period_hit, width_hit};
      end
   end

   // Level interrupt and one-cycle converter trigger
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_q         <= 1'b0;
         adc_trigger_q <= 1'b0;
      end else begin
         irq_q         <= |(status_q & irq_en_q);
         adc_trigger_q <= trig_sel_q && width_hit;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------
   // Address and data are held independently, so either may come first
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `CCPD_AXI_OKAY;
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h0;
         w_strb_q      <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q     <= s_axi_awaddr;
            aw_have_q     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            w_have_q     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q > `CCPD_ADDR_TRIGSEL || aw_addr_q[1:0] != 2'h0 ||
                             aw_addr_q == `CCPD_ADDR_TIMER ||
                             aw_addr_q == `CCPD_ADDR_STATUS) ?
                            `CCPD_AXI_SLVERR : `CCPD_AXI_OKAY;
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Register storage; only byte lane 0 is implemented
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q     <= `CCPD_RST_CTRL;
         wlow_q     <= `CCPD_RST_BYTE;
         whigh_q    <= `CCPD_RST_BYTE;
         period_q   <= `CCPD_RST_PERIOD;
         presc_q    <= `CCPD_PS_1;
         irq_en_q   <= 2'h0;
         trig_sel_q <= 1'b0;
      end else if (wr_go && w_strb_q[0]) begin
         case (aw_addr_q)
            // Output status and reserved bit are not writable
            `CCPD_ADDR_CTRL:    ctrl_q     <= w_data_q[7:0] & `CCPD_CTRL_WMASK;
            `CCPD_ADDR_WLOW:    wlow_q     <= w_data_q[7:0];
            `CCPD_ADDR_WHIGH:   whigh_q    <= w_data_q[7:0];
            `CCPD_ADDR_PERIOD:  period_q   <= w_data_q[7:0];
            `CCPD_ADDR_PRESC:   presc_q    <= w_data_q[1:0];
            `CCPD_ADDR_ENABLE:  irq_en_q   <= w_data_q[1:0];
            `CCPD_ADDR_TRIGSEL: trig_sel_q <= w_data_q[0];
            default:            ctrl_q     <= ctrl_q;
         endcase
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------
   reg [7:0] rd_val;
   reg       rd_ok;

   // Read mux; output status shows the live latch
   always @* begin
      rd_ok  = 1'b1;
      rd_val = 8'h00;
      case (s_axi_araddr)
         `CCPD_ADDR_CTRL:    rd_val = {ctrl_q[7:6], pwm_out_q, ctrl_q[4:0]};
         `CCPD_ADDR_WLOW:    rd_val = wlow_q;
         `CCPD_ADDR_WHIGH:   rd_val = whigh_q;
         `CCPD_ADDR_PERIOD:  rd_val = period_q;
         `CCPD_ADDR_TIMER:   rd_val = timer_q;
         `CCPD_ADDR_PRESC:   rd_val = {6'h00, presc_q};
         `CCPD_ADDR_STATUS:  rd_val = {6'h00, status_q};
         `CCPD_ADDR_CLEAR:   rd_val = 8'h00;
         `CCPD_ADDR_ENABLE:  rd_val = {6'h00, irq_en_q};
         `CCPD_ADDR_TRIGSEL: rd_val = {7'h00, trig_sel_q};
         default:            rd_ok  = 1'b0;
      endcase
   end

   // One read at a time; answer one cycle after the address is taken
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `CCPD_AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h000000, rd_val};
         s_axi_rresp   <= rd_ok ? `CCPD_AXI_OKAY : `CCPD_AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> tb_ccpd_pwm_duty_control.sv
`default_nettype none
`include "ccpd_consts.vh"
module tb_ccpd_pwm_duty_control;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        sleep = 1'b0;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, pwm, trig, irq, hi_done;
   logic [1:0]  bresp, rresp;
   logic [15:0] hi_len;
   logic [33:0] rq[$];
   logic [15:0] pq[$];
   int          num_errors = 0, num_checks = 0, trig_n = 0;
   initial forever #2 ref_clk = ~ref_clk;
   ccpd_top dut (.ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sleep(sleep), .pwm_out_q(pwm), .adc_trigger_q(trig), .irq_q(irq));
   ccpd_load u_load (.ref_clk(ref_clk), .pwm_in(pwm), .hi_len(hi_len), .hi_done(hi_done));
   // ---------------------------------------------------------------
   // Checking
   // ---------------------------------------------------------------
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic tmo;
      num_errors++;
      summarize;
   endtask
   // Oldest note against each answer, and against a measured pulse while a note is queued
   always @(posedge ref_clk) begin
      if (bvalid && bready) chk({bresp, 32'h0}, rq.pop_front());
      if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
      if (hi_done === 1'b1 && pq.size() > 0) chk(hi_len, pq.pop_front());
      if (trig === 1'b1) trig_n++;
   end
   // ---------------------------------------------------------------
   // Bus and pin helpers
   // ---------------------------------------------------------------
   task automatic xfer(input bit wr, input [7:0] a, input [7:0] d, input [33:0] exp);
      int n;
      rq.push_back(exp);
      @(posedge ref_clk);
      awaddr <= a;
      araddr <= a;
      wdata <= {24'h0, d};
      awvalid <= wr;
      wvalid <= wr;
      bready <= wr;
      arvalid <= !wr;
      rready <= !wr;
      for (n = 0; n < 100; n++) begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (arready) arvalid <= 1'b0;
         if ((bvalid && bready) || (rvalid && rready)) break;
      end
      if (n == 100) tmo;
      bready <= 1'b0;
      rready <= 1'b0;
   endtask
   task automatic wr(input [7:0] a, input [7:0] d);
      xfer(1'b1, a, d, 34'h0);
   endtask
   task automatic rd(input [7:0] a, input [7:0] d);
      xfer(1'b0, a, 8'h0, {26'h0, d});
   endtask
   // Width placed by the alignment bit, channel enabled in PWM mode
   task automatic setw(input bit fmt, input [9:0] w);
      wr(`CCPD_ADDR_WLOW, fmt ? {w[1:0], 6'h0} : w[7:0]);
      wr(`CCPD_ADDR_WHIGH, fmt ? w[9:2] : {6'h0, w[9:8]});
      wr(`CCPD_ADDR_CTRL, {3'h4, fmt, `CCPD_MODE_PWM});
   endtask
   task automatic skip(input int k);
      int n;
      for (n = 0; k > 0 && n < 5000; n++) begin
         @(posedge ref_clk);
         if (hi_done === 1'b1) k--;
      end
      if (k > 0) tmo;
      @(posedge ref_clk);
   endtask
   // Start of a fresh high phase
   task automatic rise;
      int n;
      for (n = 0; n < 5000 && pwm !== 1'b0; n++) @(posedge ref_clk);
      if (n == 5000) tmo;
      for (n = 0; n < 5000 && pwm !== 1'b1; n++) @(posedge ref_clk);
      if (n == 5000) tmo;
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int i;
      logic [9:0] w;
      void'($urandom(22));
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(`CCPD_ADDR_CTRL, 8'h00);
      rd(`CCPD_ADDR_PERIOD, 8'hff);
      rd(`CCPD_ADDR_WLOW, 8'h00);
      xfer(1'b0, 8'h28, 8'h0, {2'h2, 32'h0});
      xfer(1'b1, `CCPD_ADDR_TIMER, 8'h01, {2'h2, 32'h0});
      wr(`CCPD_ADDR_PERIOD, 8'h03);
      wr(`CCPD_ADDR_ENABLE, 8'h01);
      wr(`CCPD_ADDR_TRIGSEL, 8'h01);
      // Random widths in both alignments at 1:1
      for (i = 0; i < 4; i++) begin
         w = 10'($urandom % 15 + 1);
         setw(1'($urandom % 2), w);
         skip(2);
         pq.push_back({6'h0, w});
         skip(1);
      end
      chk(trig_n > 0, 1'b1);
      // Stopping the channel stops new events, so flags stay put
      wr(`CCPD_ADDR_CTRL, 8'h0f);
      rd(`CCPD_ADDR_CTRL, 8'h0f);
      rd(`CCPD_ADDR_STATUS, 8'h03);
      chk(irq, 1'b1);
      for (i = 0; i < 3; i++) begin
         if (i == 2) wr(`CCPD_ADDR_CLEAR, 8'h03);
         else wr(`CCPD_ADDR_ENABLE, i[7:0]);
         repeat (2) @(posedge ref_clk);
         chk(irq, i == 1);
      end
      rd(`CCPD_ADDR_STATUS, 8'h00);
      setw(1'b0, 10'h3ff);
      wr(`CCPD_ADDR_CTRL, 8'haf);
      repeat (40) @(posedge ref_clk);
      rd(`CCPD_ADDR_CTRL, 8'haf);
      setw(1'b0, 10'h0);
      repeat (40) @(posedge ref_clk);
      rd(`CCPD_ADDR_CTRL, 8'h8f);
      // Full ten-bit width only fits the largest period
      wr(`CCPD_ADDR_PERIOD, 8'hff);
      setw(1'b0, 10'h3fe);
      skip(2);
      pq.push_back(16'd1022);
      skip(1);
      wr(`CCPD_ADDR_PERIOD, 8'h03);
      setw(1'b0, 10'd6);
      for (i = 0; i < 4; i++) begin
         wr(`CCPD_ADDR_PRESC, i[7:0]);
         skip(2);
         pq.push_back(16'd6 << (2 * i));
         skip(1);
      end
      // New width during a pulse waits for the next period
      wr(`CCPD_ADDR_PRESC, 8'h01);
      skip(1);
      rise;
      setw(1'b0, 10'd2);
      pq.push_back(16'd24);
      pq.push_back(16'd8);
      skip(2);
      rise;
      sleep <= 1'b1;
      repeat (10) @(posedge ref_clk);
      sleep <= 1'b0;
      pq.push_back(16'd18);
      skip(1);
      summarize;
   end
endmodule
`default_nettype wire
